// File: testbench/ccsc_chk.sv
// checker: port assertions of the cpu clock source control
`timescale 1ns/1ps
module ccsc_chk
  import ccsc_pkg::*;
#(
  parameter bit INT_OSC_STOPPABLE = 1'b1 // stoppable build option
)(
  // watched ports
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  input wire logic          halt_req,
  input wire logic          wake_req,
  input wire ccsc_osc_ctl_t osc_ctl,
  input wire logic          cpu_clk_en,
  input wire logic          watchdog_clk_en,
  input wire logic          clk_monitor_reset,
  input wire logic          sys_reset
);
  // ****
  // decode and sequences
  // ****
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable; // access phase
  wire int_wr = acc && pwrite && paddr == ADDR_INT_OSC; // internal osc mode write
  wire hit = paddr inside {ADDR_CLOCK_MODE, ADDR_INT_OSC, ADDR_MAIN_OSC,
                           ADDR_PROC_CLK, ADDR_STAB_STATUS, ADDR_STAB_SELECT};
  // proc ctrl write with feedback bit v
  sequence s_fb_wr(logic v);
    acc && pwrite && paddr == ADDR_PROC_CLK && pwdata[6] == v;
  endsequence
  // halt taken, no wake since
  sequence s_halted;
    INT_OSC_STOPPABLE && halt_req ##1 !wake_req [*3];
  endsequence
  // ****
  // assertions
  // ****
  a_bad_addr: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_good_addr: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  a_reset_osc_off: assert property (sys_reset && $past(sys_reset) |-> !osc_ctl.int_run && !osc_ctl.main_run)
    else $error("oscillator runs in reset");
  a_no_cpu_rst: assert property (sys_reset |-> !cpu_clk_en)
    else $error("cpu clock during reset");
  a_startup_hold: assert property ($fell(sys_reset) |-> !cpu_clk_en [*8])
    else $error("cpu clock too soon after reset");
  a_int_stop_why: assert property ($fell(osc_ctl.int_run) |-> $past(int_wr) || sys_reset || $past(sys_reset))
    else $error("internal osc stopped without cause");
  a_fb_set: assert property (s_fb_wr(1'b1) |=> osc_ctl.fb_dis)
    else $error("feedback resistor not disabled");
  a_fb_clear: assert property (s_fb_wr(1'b0) |=> !osc_ctl.fb_dis)
    else $error("feedback resistor not enabled");
  a_mon_reset: assert property (clk_monitor_reset |-> sys_reset ##1 !cpu_clk_en && !osc_ctl.fb_dis)
    else $error("monitor pulse without reset");
  a_halt_wdt: assert property (s_halted |-> !watchdog_clk_en)
    else $error("watchdog clock in halt");
endmodule // ccsc_chk

bind ccsc_top ccsc_chk #(.INT_OSC_STOPPABLE(INT_OSC_STOPPABLE)) ccsc_chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .halt_req,
  .wake_req, .osc_ctl, .cpu_clk_en, .watchdog_clk_en, .clk_monitor_reset, .sys_reset);

// File: testbench/test_ccsc_top.sv
// testbench: directed scenarios for the cpu clock source control
`timescale 1ns/1ps
module test_ccsc_top;
  import ccsc_pkg::*;
  // ****
  // signals
  // ****
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, main_kill;
  logic             halt_req, stop_req, wake_req, int_osc_clk, main_osc_clk, sub_osc_clk;
  logic             cpu_clk_en, watchdog_clk_en, clk_monitor_reset, sys_reset;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata;
  logic [3:0]       rst_src; // pin, power-on, low voltage, watchdog
  logic [PRE_W-1:0] presc_en;
  ccsc_osc_ctl_t    osc_ctl;
  int               oc, mismatches, tests_run;
  wire              reset_pin_n = !rst_src[0];
  wire              power_on_clear = rst_src[1];
  wire              low_voltage_detect = rst_src[2];
  wire              watchdog_timer_ovf = rst_src[3];
  ccsc_top #(.INT_OSC_STOPPABLE(1'b1), .SUB_CLK_USED(1'b1), .MON_CYC(8)) ccsc_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .int_osc_clk, .main_osc_clk, .sub_osc_clk, .reset_pin_n, .power_on_clear, .low_voltage_detect,
    .watchdog_timer_ovf, .halt_req, .stop_req, .wake_req, .osc_ctl, .cpu_clk_en, .presc_en,
    .watchdog_clk_en, .clk_monitor_reset, .sys_reset);
  // ****
  // clock and oscillators
  // ****
  always #12.5 pclk = !pclk;
  // periods 8, 6 and 20 pclk, each gated by its run enable
  always @(posedge pclk)
  begin
    oc <= oc + 1;
    if (osc_ctl.int_run && oc % 4 == 0)
      int_osc_clk <= !int_osc_clk;
    if (osc_ctl.main_run && !main_kill && oc % 3 == 0)
      main_osc_clk <= !main_osc_clk;
    if (osc_ctl.sub_run && oc % 10 == 0)
      sub_osc_clk <= !sub_osc_clk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  // read until bit b is set, bounded
  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] r;
    int n;
    n = 0;
    r = '0;
    while (r[b] !== 1'b1 && n++ < 20000)
      rd(a, r);
  endtask
  // cycles to next pulse: 0 cpu, 1 prescaler, 2 monitor
  task automatic until_pulse(input int k, output int n);
    n = 0;
    do
      @(negedge pclk);
    while (!(k == 0 ? cpu_clk_en === 1'b1 : k == 1 ? presc_en[0] === 1'b1 : clk_monitor_reset === 1'b1)
           && ++n < 400);
  endtask
  // stabilised main osc becomes the cpu clock
  task automatic go_main;
    logic [31:0] r;
    poll(ADDR_STAB_STATUS, 4);
    rd(ADDR_STAB_STATUS, r);
    chk("stab 2^11", r[4], 1'b1);
    wr(ADDR_CLOCK_MODE, 32'h1);
    poll(ADDR_CLOCK_MODE, 1);
    rd(ADDR_CLOCK_MODE, r);
    chk("on main", r[1:0], 2'h3);
  endtask
  // ****
  // scenarios
  // ****
  // start-up on internal osc
  task automatic t_start;
    logic [31:0] r;
    int n;
    until_pulse(0, n);
    chk("startup", 32'(n >= 120 && n <= 176), 32'h1);
    until_pulse(1, n);
    until_pulse(1, n);
    chk("int prescale", 32'(n), 32'd15);
    rd(ADDR_CLOCK_MODE, r);
    chk("mode reg", r[1:0], 2'h0);
    rd(ADDR_STAB_SELECT, r);
    chk("stab sel", r, 32'(STAB_SEL_RESET));
    wr(ADDR_INT_OSC, 32'h1);
    @(negedge pclk);
    chk("int kept", osc_ctl.int_run, 1'b1);
    n = 0;
    repeat (40)
      @(negedge pclk) n += int'(watchdog_clk_en);
    chk("wdt run", 32'(n), 32'd5);
    wr(ADDR_PROC_CLK, 32'h1);
    until_pulse(0, n);
    until_pulse(0, n);
    chk("cpu div 2", 32'(n), 32'd15);
    wr(ADDR_PROC_CLK, 32'h0);
  endtask
  // refused accesses and main osc control on internal
  task automatic t_bad;
    logic [31:0] r;
    logic e;
    apb(1'b1, 8'h18, 32'hffffffff, r, e);
    chk("wr err", e, 1'b1);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("rd err", e, 1'b1);
    chk("rd data", r, 32'h0);
    wr(ADDR_STAB_SELECT, 32'h0);
    wr(ADDR_STAB_SELECT, 32'h1);
    rd(ADDR_STAB_SELECT, r);
    chk("sel 2^11", r, 32'h1);
    wr(ADDR_MAIN_OSC, 32'h80);
    @(negedge pclk);
    chk("main stop", osc_ctl.main_run, 1'b0);
    wr(ADDR_MAIN_OSC, 32'h0);
    @(negedge pclk);
    chk("main run", osc_ctl.main_run, 1'b1);
  endtask
  // main osc: prescaler, internal stop, monitor reset
  task automatic t_main;
    logic [31:0] r;
    int n;
    go_main;
    until_pulse(1, n);
    until_pulse(1, n);
    chk("main prescale", 32'(n), 32'd11);
    wr(ADDR_INT_OSC, 32'h1);
    @(negedge pclk);
    chk("int stopped", osc_ctl.int_run, 1'b0);
    wr(ADDR_INT_OSC, 32'h0);
    main_kill <= 1'b1;
    until_pulse(2, n);
    chk("monitor", 32'(n < 400), 32'h1);
    @(posedge pclk);
    main_kill <= 1'b0;
    until_pulse(0, n);
    rd(ADDR_CLOCK_MODE, r);
    chk("after monitor", r[1:0], 2'h0);
  endtask
  // subsystem clock: feedback, refused moves, halt, stop
  task automatic t_sub;
    logic [31:0] r;
    int n;
    go_main;
    wr(ADDR_PROC_CLK, 32'h50);
    poll(ADDR_PROC_CLK, 5);
    rd(ADDR_PROC_CLK, r);
    chk("on sub", r[6:4], 3'h7);
    wr(ADDR_CLOCK_MODE, 32'h0);
    rd(ADDR_CLOCK_MODE, r);
    chk("no sub to int", r[0], 1'b1);
    wr(ADDR_PROC_CLK, 32'hd0);
    @(negedge pclk);
    chk("main stop sub", osc_ctl.main_run, 1'b0);
    @(posedge pclk);
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    n = 0;
    repeat (40)
      @(negedge pclk) n += int'(watchdog_clk_en);
    chk("wdt gated", 32'(n), 32'h0);
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    until_pulse(0, n);
    chk("stop refused", 32'(n < 400), 32'h1);
    wr(ADDR_PROC_CLK, 32'h0);
    @(negedge pclk);
    chk("fb on", osc_ctl.fb_dis, 1'b0);
  endtask
  // each reset source restores the reset state
  task automatic t_sources;
    logic [31:0] r;
    int n;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_STAB_SELECT, 32'h1);
      rst_src <= 4'h1 << i;
      repeat (8)
        @(negedge pclk);
      chk("osc off", {osc_ctl.int_run, osc_ctl.main_run}, 2'h0);
      @(posedge pclk);
      rst_src <= 4'h0;
      until_pulse(0, n);
      rd(ADDR_STAB_SELECT, r);
      chk("sel reset", r, 32'h5);
      rd(ADDR_CLOCK_MODE, r);
      chk("select reset", r, 32'h0);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // main sequence and watchdog
  // ****
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, halt_req, stop_req, wake_req, main_kill} = '0;
    {int_osc_clk, main_osc_clk, sub_osc_clk, paddr, pwdata, rst_src} = '0;
    {oc, mismatches, tests_run} = '0;
    repeat (16)
      @(posedge pclk);
    presetn <= 1'b1;
    t_start;
    t_bad;
    t_main;
    t_sub;
    t_sources;
    close_out;
  end
  initial
  begin
    #2500000;
    mismatches++;
    close_out;
  end
endmodule // test_ccsc_top

// File: verilog/ccsc_pkg.sv
// package: constants, register map and types of the cpu clock source control
package ccsc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CLOCK_MODE  = 8'h00; // clock_mode_reg
  localparam logic [7:0] ADDR_INT_OSC     = 8'h04; // internal_osc_mode_reg
  localparam logic [7:0] ADDR_MAIN_OSC    = 8'h08; // main_osc_ctrl_reg
  localparam logic [7:0] ADDR_PROC_CLK    = 8'h0c; // processor_clock_ctrl_reg
  localparam logic [7:0] ADDR_STAB_STATUS = 8'h10; // stab_status_reg
  localparam logic [7:0] ADDR_STAB_SELECT = 8'h14; // stab_select_reg

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SELECT      = 0; // cpu_clock_select
  localparam int BIT_STATUS      = 1; // cpu_clock_status
  localparam int BIT_INT_STOP    = 0; // internal_osc_stop
  localparam int BIT_MAIN_STOP   = 7; // main osc stop while on internal osc
  localparam int BIT_SUB_MSTOP   = 7; // main osc stop while on subsystem clock
  localparam int BIT_FB_DISABLE  = 6; // sub_feedback_disable
  localparam int BIT_SUB_STATUS  = 5; // subsystem clock drives the cpu
  localparam int BIT_SUB_SELECT  = 4; // subsystem clock requested
  localparam int DIV_LSB         = 0; // prescaler division field, 3 bits

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [2:0] STAB_SEL_RESET = 3'h5;  // longest wait after reset
  localparam logic [4:0] STARTUP_CYC    = 5'h11; // internal osc cycles withheld
  localparam int         STAB_W         = 17;    // stabilisation counter width
  localparam int         MON_TIMEOUT    = 64;    // pclk cycles without a main tick
  localparam int         PRE_W          = 5;     // prescaler stages

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SRC_INT  = 2'b00, // internal oscillator
    SRC_MAIN = 2'b01, // main oscillator
    SRC_SUB  = 2'b10  // subsystem oscillator
  } ccsc_src_t;

  typedef enum logic [1:0] {
    MODE_RUN  = 2'b00, // cpu clocked
    MODE_HALT = 2'b01, // cpu clock gated, oscillators on
    MODE_STOP = 2'b10, // main oscillator stopped
    MODE_WAIT = 2'b11  // waiting main oscillator stabilisation
  } ccsc_mode_t;

  typedef struct packed {
    logic int_run;   // internal oscillator enable
    logic main_run;  // main oscillator enable
    logic sub_run;   // subsystem oscillator enable
    logic fb_dis;    // subsystem feedback resistor disabled
  } ccsc_osc_ctl_t;

endpackage

// File: verilog/ccsc_top.sv
// module: cpu clock source control with apb register slave
//
// Behaviour
// - internal osc runs from reset release on
// - parameter fixes internal osc software stoppable
// - prescaler divides main osc when selected
// - prescaler divides internal osc when selected
// - any reset clears cpu clock select
// - cpu clock withheld seventeen internal osc cycles
// - both oscillators stopped during reset
// - status bit one reports cpu source
// - internal osc stop only when allowed
// - main osc control only on internal osc
// - sub mode: halt allowed, stop refused
// - stop release on main waits selection
// - bit six disables sub feedback resistor
// - stoppable, no sub: watchdog halted standby
// - stop bit zero keeps internal osc running
// - stoppable with sub: watchdog gated standby
// - no direct sub to internal switch
// - every reset source resets clock generator
// - clock monitor resets on main osc loss
// - source change delayed, status shows old
`timescale 1ns/1ps

module ccsc_top
  import ccsc_pkg::*;
#(
  parameter bit INT_OSC_STOPPABLE = 1'b1, // build option: internal osc stoppable
  parameter bit SUB_CLK_USED      = 1'b1, // subsystem clock fitted
  parameter int MON_CYC           = ccsc_pkg::MON_TIMEOUT
)(
  // apb clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // oscillator outputs and reset sources, asynchronous pins
  input  wire logic                   int_osc_clk,
  input  wire logic                   main_osc_clk,
  input  wire logic                   sub_osc_clk,
  input  wire logic                   reset_pin_n,
  input  wire logic                   power_on_clear,
  input  wire logic                   low_voltage_detect,
  input  wire logic                   watchdog_timer_ovf,
  // cpu standby requests, same clock
  input  wire logic                   halt_req,
  input  wire logic                   stop_req,
  input  wire logic                   wake_req,
  // oscillator control and clock enables
  output ccsc_pkg::ccsc_osc_ctl_t     osc_ctl,
  output logic                        cpu_clk_en,
  output logic [ccsc_pkg::PRE_W-1:0]  presc_en,
  output logic                        watchdog_clk_en,
  output logic                        clk_monitor_reset,
  output logic                        sys_reset
);

  // ****************************************
  // pin synchronisers and tick detection
  // ****************************************
  logic [2:0] osc_meta;  // first stage, read only by second
  logic [2:0] osc_sync;  // second stage
  logic [2:0] osc_prev;  // edge detect history
  logic [2:0] osc_tick;  // rising edge pulse per oscillator
  logic [2:0] osc_pin;   // oscillator pins as a vector

  assign osc_pin = {sub_osc_clk, main_osc_clk, int_osc_clk};

  // one synchroniser and edge detector per oscillator
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_osc
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          osc_meta[gi] <= 1'b0;
          osc_sync[gi] <= 1'b0;
          osc_prev[gi] <= 1'b0;
        end
        else
        begin
          osc_meta[gi] <= osc_pin[gi];
          osc_sync[gi] <= osc_meta[gi];
          osc_prev[gi] <= osc_sync[gi];
        end
      end
      assign osc_tick[gi] = osc_sync[gi] & ~osc_prev[gi];
    end
  endgenerate

  // reset source synchronisers
  logic [3:0] rst_meta;  // first stage
  logic [3:0] rst_sync;  // second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_meta <= 4'h0;
      rst_sync <= 4'h0;
    end
    else
    begin
      rst_meta <= {~reset_pin_n, power_on_clear, low_voltage_detect, watchdog_timer_ovf};
      rst_sync <= rst_meta;
    end
  end

  // ****************************************
  // registers and state
  // ****************************************
  logic             select_reg;     // cpu_clock_select
  logic             int_stop_reg;   // internal_osc_stop
  logic             main_stop_reg;  // main osc stop, internal osc mode
  logic             sub_mstop_reg;  // main osc stop, subsystem mode
  logic             fb_dis_reg;     // sub_feedback_disable
  logic             sub_sel_reg;    // subsystem clock request
  logic [2:0]       div_reg;        // prescaler division
  logic [2:0]       stab_sel_reg;   // stabilisation wait selection
  ccsc_src_t        src_reg;        // source driving the cpu now
  logic             old_done_reg;   // old source finished its pulse
  ccsc_mode_t       mode_reg;       // standby state
  logic [4:0]       start_cnt_reg;  // startup withhold counter
  logic [STAB_W-1:0] stab_cnt_reg;  // main osc stabilisation counter
  logic [PRE_W-1:0] pre_cnt_reg;    // prescaler counter
  logic [6:0]       mon_cnt_reg;    // pclk cycles since last main tick
  logic             mon_rst_reg;    // clock monitor reset pulse

  // ****************************************
  // reset combine and derived conditions
  // ****************************************
  wire       on_int     = (src_reg == SRC_INT);
  wire       on_sub     = (src_reg == SRC_SUB);
  wire       status_bit = (src_reg != SRC_INT);
  wire       started    = (start_cnt_reg == STARTUP_CYC);
  wire       main_off   = on_sub ? sub_mstop_reg : main_stop_reg;
  wire       standby    = (mode_reg != MODE_RUN);
  ccsc_src_t req_src;
  ccsc_src_t next_src;

  assign sys_reset = (|rst_sync) | mon_rst_reg;
  assign clk_monitor_reset = mon_rst_reg;

  // requested source from the select bits
  assign req_src = sub_sel_reg ? SRC_SUB : (select_reg ? SRC_MAIN : SRC_INT);
  assign next_src = req_src;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr_en    = psel & penable & pwrite;
  wire hit_cm   = (paddr == ADDR_CLOCK_MODE);
  wire hit_io   = (paddr == ADDR_INT_OSC);
  wire hit_mo   = (paddr == ADDR_MAIN_OSC);
  wire hit_pc   = (paddr == ADDR_PROC_CLK);
  wire hit_ss   = (paddr == ADDR_STAB_STATUS);
  wire hit_sl   = (paddr == ADDR_STAB_SELECT);
  wire mapped   = hit_cm | hit_io | hit_mo | hit_pc | hit_ss | hit_sl;

  // zero wait state slave, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // stabilisation status bits, set in order and held
  wire [4:0] stab_status = {|stab_cnt_reg[STAB_W-1:11], |stab_cnt_reg[STAB_W-1:13], |stab_cnt_reg[STAB_W-1:14],
                            |stab_cnt_reg[STAB_W-1:15], stab_cnt_reg[16]};

  // wait target selected for stop release
  logic [STAB_W-1:0] stab_target;
  always_comb
  begin
    unique case (stab_sel_reg)
      3'h1:    stab_target = 17'h00800;
      3'h2:    stab_target = 17'h02000;
      3'h3:    stab_target = 17'h04000;
      3'h4:    stab_target = 17'h08000;
      default: stab_target = 17'h10000;
    endcase
  end
  wire stab_done = (stab_cnt_reg >= stab_target);

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_cm)
      rd_mux = {30'h0, status_bit, select_reg};
    else if (hit_io)
      rd_mux = {31'h0, int_stop_reg};
    else if (hit_mo)
      rd_mux = {24'h0, main_stop_reg, 7'h00};
    else if (hit_pc)
      rd_mux = {24'h0, sub_mstop_reg, fb_dis_reg, on_sub, sub_sel_reg, 1'b0, div_reg};
    else if (hit_ss)
      rd_mux = {27'h0, stab_status};
    else if (hit_sl)
      rd_mux = {29'h0, stab_sel_reg};
  end

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_rd)
      prdata <= rd_mux;
  end

  // ****************************************
  // control register writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      select_reg    <= 1'b0;
      int_stop_reg  <= 1'b0;
      main_stop_reg <= 1'b0;
      sub_mstop_reg <= 1'b0;
      fb_dis_reg    <= 1'b0;
      sub_sel_reg   <= 1'b0;
      div_reg       <= 3'h0;
      stab_sel_reg  <= STAB_SEL_RESET;
    end
    else if (sys_reset)
    begin
      // any reset source forces the internal osc again
      select_reg    <= 1'b0;
      int_stop_reg  <= 1'b0;
      main_stop_reg <= 1'b0;
      sub_mstop_reg <= 1'b0;
      fb_dis_reg    <= 1'b0;
      sub_sel_reg   <= 1'b0;
      div_reg       <= 3'h0;
      stab_sel_reg  <= STAB_SEL_RESET;
    end
    else if (wr_en)
    begin
      // select moves only between internal and main osc
      if (hit_cm && !on_sub && !sub_sel_reg)
        select_reg <= pwdata[BIT_SELECT];
      // stop allowed only when stoppable and cpu off internal osc
      if (hit_io && INT_OSC_STOPPABLE && status_bit)
        int_stop_reg <= pwdata[BIT_INT_STOP];
      // main osc control only while internal osc drives the cpu
      if (hit_mo && on_int)
        main_stop_reg <= pwdata[BIT_MAIN_STOP];
      if (hit_pc)
      begin
        if (on_sub)
          sub_mstop_reg <= pwdata[BIT_SUB_MSTOP];
        fb_dis_reg <= pwdata[BIT_FB_DISABLE];
        div_reg    <= pwdata[DIV_LSB +: 3];
        // sub entered only from main, left only to main
        if (SUB_CLK_USED && select_reg && (src_reg == SRC_MAIN || on_sub))
          sub_sel_reg <= pwdata[BIT_SUB_SELECT];
      end
      if (hit_sl && pwdata[2:0] >= 3'h1 && pwdata[2:0] <= 3'h5)
        stab_sel_reg <= pwdata[2:0];
    end
  end

  // ****************************************
  // startup withhold counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_cnt_reg <= 5'h00;
    else if (sys_reset)
      start_cnt_reg <= 5'h00;
    else if (!started && osc_tick[0])
      start_cnt_reg <= start_cnt_reg + 5'h01;
  end

  // ****************************************
  // glitch free source switch
  // ****************************************
  // the old source completes its pulse, then the switch lands on a new tick
  wire old_tick = osc_tick[src_reg];
  wire new_tick = osc_tick[next_src];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_reg      <= SRC_INT;
      old_done_reg <= 1'b0;
    end
    else if (sys_reset)
    begin
      src_reg      <= SRC_INT;
      old_done_reg <= 1'b0;
    end
    else if (next_src == src_reg)
      old_done_reg <= 1'b0;
    else if (!old_done_reg)
      old_done_reg <= old_tick;
    else if (new_tick)
    begin
      src_reg      <= next_src;
      old_done_reg <= 1'b0;
    end
  end

  // ****************************************
  // standby state machine
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= MODE_RUN;
    else if (sys_reset)
      mode_reg <= MODE_RUN;
    else
    begin
      unique case (mode_reg)
        MODE_RUN:
        begin
          // stop refused on the subsystem clock
          if (stop_req && !on_sub)
            mode_reg <= MODE_STOP;
          else if (halt_req)
            mode_reg <= MODE_HALT;
        end
        MODE_HALT:
        begin
          if (wake_req)
            mode_reg <= MODE_RUN;
        end
        MODE_STOP:
        begin
          // on main osc the wait follows the selection
          if (wake_req)
            mode_reg <= (src_reg == SRC_MAIN) ? MODE_WAIT : MODE_RUN;
        end
        MODE_WAIT:
        begin
          if (stab_done)
            mode_reg <= MODE_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // main osc stabilisation counter
  // ****************************************
  wire stab_clr = sys_reset | (mode_reg == MODE_STOP) | main_off;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stab_cnt_reg <= '0;
    else if (stab_clr)
      stab_cnt_reg <= '0;
    else if (osc_tick[1] && !stab_cnt_reg[STAB_W-1])
      stab_cnt_reg <= stab_cnt_reg + 17'h00001;
  end

  // ****************************************
  // clock monitor
  // ****************************************
  // armed once the main osc has run stable and is meant to run
  wire mon_arm = osc_ctl.main_run & stab_status[4];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_cnt_reg <= 7'h00;
      mon_rst_reg <= 1'b0;
    end
    else
    begin
      mon_rst_reg <= 1'b0;
      if (!mon_arm || osc_tick[1] || mon_rst_reg)
        mon_cnt_reg <= 7'h00;
      else if (mon_cnt_reg == 7'(MON_CYC - 1))
        mon_rst_reg <= 1'b1;
      else
        mon_cnt_reg <= mon_cnt_reg + 7'h01;
    end
  end

  // ****************************************
  // prescaler and cpu clock enables
  // ****************************************
  wire src_tick = osc_tick[src_reg];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_cnt_reg <= '0;
    else if (sys_reset || !started)
      pre_cnt_reg <= '0;
    else if (src_tick && !on_sub)
      pre_cnt_reg <= pre_cnt_reg + 5'h01;
  end

  // stage i pulses once per 2^(i+1) source ticks
  genvar gp;
  generate
    for (gp = 0; gp < PRE_W; gp++)
    begin : g_pre
      assign presc_en[gp] = src_tick & ~on_sub & ~sys_reset & started &
                            (&pre_cnt_reg[gp:0]) & (mode_reg != MODE_STOP);
    end
  endgenerate

  // cpu enable: divided source, gated by startup and standby
  logic div_hit;
  always_comb
  begin
    unique case (div_reg)
      3'h0:    div_hit = 1'b1;
      3'h1:    div_hit = pre_cnt_reg[0];
      3'h2:    div_hit = &pre_cnt_reg[1:0];
      3'h3:    div_hit = &pre_cnt_reg[2:0];
      default: div_hit = &pre_cnt_reg[3:0];
    endcase
  end
  assign cpu_clk_en = src_tick & started & ~sys_reset & ~standby &
                      (on_sub | div_hit);

  // ****************************************
  // oscillator enables and watchdog clock
  // ****************************************
  // internal osc halts in reset and on its stop bit under the option
  assign osc_ctl.int_run  = ~sys_reset & ~(INT_OSC_STOPPABLE & int_stop_reg);
  // main osc off in reset, stop, or by its stop bits
  assign osc_ctl.main_run = ~sys_reset & ~main_off & (mode_reg != MODE_STOP);
  // subsystem osc never stopped by standby
  assign osc_ctl.sub_run  = SUB_CLK_USED;
  assign osc_ctl.fb_dis   = fb_dis_reg;

  // watchdog counts internal osc ticks, gated in standby when stoppable
  assign watchdog_clk_en = osc_tick[0] & osc_ctl.int_run & ~sys_reset &
                           ~(INT_OSC_STOPPABLE & standby);

endmodule // ccsc_top
